// *** logic/dsl_defines.vh ***
// constants for the serial load control block
`ifndef DSL_DEFINES_VH
`define DSL_DEFINES_VH
`define DSL_WORD_BITS     24
`define DSL_DATA_BITS     20
`define DSL_CNT_BITS      5
`define DSL_WORD_COUNT    5'h18
`define DSL_RW_BIT        23
`define DSL_ADDR_HI       22
`define DSL_ADDR_LO       20
`define DSL_ADDR_DAC      3'h1
`define DSL_ADDR_CTRL     3'h2
`define DSL_ADDR_CLR      3'h3
`define DSL_CTRL_TWOS_BIT 1
`define DSL_DAC_RESET     20'h00000
`define DSL_CTRL_RESET    20'h00000
`define DSL_CLR_RESET     20'h00000
`endif

// *** logic/dsl_edge_sync.v ***
// two-flop synchroniser with level and edge outputs
`timescale 1ns/100ps
module dsl_edge_sync #(
  parameter INIT = 1'b1
) (
  input  wire sys_clk,
  input  wire rst,
  input  wire async_in,
  output reg  level,
  output wire rise,
  output wire fall
);
  reg meta;

  // only level reads meta, edges compare two settled copies
  reg prev;
  always @(posedge sys_clk) begin
    if (rst) begin
      meta  <= INIT;
      level <= INIT;
      prev  <= INIT;
    end else begin
      meta  <= async_in;
      level <= meta;
      prev  <= level;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;
endmodule // dsl_edge_sync

// *** logic/dsl_serial_load.v ***
// serial load and output update control of the converter
// Notes on behaviour
// RULE_01: a low reset_n returns every register and the output to power-on.
// RULE_02: a low clear_n loads the clear code into the converter register.
// RULE_03: the clear code is read in the coding chosen, binary or twos comp.
// RULE_04: with load_output_n low the output updates when a frame ends.
// RULE_05: with load_output_n high only the input register takes the word.
// RULE_06: the host always drives load_output_n, never leaving it floating.
// RULE_07: readback bits move onto serial_data_out at serial_clock rises.
// RULE_08: a 24-bit shift register samples serial_data_in at clock falls.
// RULE_09: the host keeps serial_clock at or below 35 MHz when writing.
// RULE_10: a low frame_select_n opens a frame and enables shifting.
// RULE_11: words travel most significant bit first.
// RULE_12: bit 23 is read/write, bits 22..20 address, bits 19..0 data.
// RULE_13: the host keeps serial_clock at or below 16 MHz on readback.
// RULE_14: serial_data_out is released once frame_select_n rises.
// RULE_15: with frame_select_n high, clock and data are ignored.
// RULE_16: a frame acts only after exactly 24 falling clock edges.
`timescale 1ns/100ps
`include "dsl_defines.vh"
module dsl_serial_load (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        reset_n,
  input  wire        clear_n,
  input  wire        load_output_n,
  input  wire        frame_select_n,
  input  wire        serial_clock,
  input  wire        serial_data_in,
  output reg         serial_data_out,
  output reg         serial_data_out_oe,
  output reg  [19:0] dac_code,
  output wire [19:0] output_code,
  output reg         twos_comp,
  output reg         output_update
);
  wire reset_n_s;
  wire clear_n_s;
  wire clear_fall;
  wire load_n_s;
  wire load_fall;
  wire frame_n_s;
  wire frame_rise;
  wire frame_fall;
  wire sclk_rise;
  wire sclk_fall;
  wire sdi_s;

  reg  [23:0] in_shift;
  reg  [23:0] out_shift;
  reg  [4:0]  bit_count;
  reg  [19:0] input_reg;
  reg  [19:0] ctrl_reg;
  reg  [19:0] clear_code;
  reg         update_pending;
  reg         read_pending;
  reg  [2:0]  read_addr;
  reg         read_active;
  reg  [19:0] read_data;

  wire        word_ok;
  wire        is_read;
  wire [2:0]  word_addr;
  wire [19:0] word_data;
  wire        dev_rst;

  dsl_edge_sync #(.INIT(1'b0)) u_reset (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (reset_n),
    .level    (reset_n_s),
    .rise     (),
    .fall     ()
  );
  dsl_edge_sync #(.INIT(1'b1)) u_clear (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (clear_n),
    .level    (clear_n_s),
    .rise     (),
    .fall     (clear_fall)
  );
  // the pin is assumed driven, so its level is trusted as is
  dsl_edge_sync #(.INIT(1'b1)) u_load (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (load_output_n),
    .level    (load_n_s),
    .rise     (),
    .fall     (load_fall)
  );
  dsl_edge_sync #(.INIT(1'b1)) u_frame (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (frame_select_n),
    .level    (frame_n_s),
    .rise     (frame_rise),
    .fall     (frame_fall)
  );
  dsl_edge_sync #(.INIT(1'b0)) u_sclk (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (serial_clock),
    .level    (),
    .rise     (sclk_rise),
    .fall     (sclk_fall)
  );
  // data takes the same path as the clock so both line up in time
  dsl_edge_sync #(.INIT(1'b0)) u_sdi (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (serial_data_in),
    .level    (sdi_s),
    .rise     (),
    .fall     ()
  );

  // RULE_01 device reset
  assign dev_rst = rst | ~reset_n_s;

  // RULE_12 word fields
  assign is_read   = in_shift[`DSL_RW_BIT];
  assign word_addr = in_shift[`DSL_ADDR_HI:`DSL_ADDR_LO];
  assign word_data = in_shift[`DSL_DATA_BITS-1:0];

  // RULE_16 exact count
  assign word_ok = frame_rise && (bit_count == `DSL_WORD_COUNT);

  // RULE_03 coding applied
  assign output_code = twos_comp ? {~dac_code[19], dac_code[18:0]}
                                 : dac_code;

  always @* begin
    case (read_addr)
      `DSL_ADDR_DAC:  read_data = dac_code;
      `DSL_ADDR_CTRL: read_data = ctrl_reg;
      `DSL_ADDR_CLR:  read_data = clear_code;
      default:        read_data = 20'h00000;
    endcase
  end

  // input side of the frame
  always @(posedge sys_clk) begin
    if (dev_rst) begin
      in_shift  <= 24'h000000;
      bit_count <= 5'h00;
    end else if (frame_fall) begin
      bit_count <= 5'h00;
    // RULE_15 idle ignored
    end else if (!frame_n_s && sclk_fall) begin
      // RULE_08 RULE_11 msb first
      in_shift <= {in_shift[22:0], sdi_s};
      // RULE_10 frame enables shifting
      if (bit_count != 5'h1F) begin
        bit_count <= bit_count + 5'h01;
      end
    end
  end

  // readback side, one frame after the read request
  always @(posedge sys_clk) begin
    if (dev_rst) begin
      out_shift          <= 24'h000000;
      serial_data_out    <= 1'b0;
      serial_data_out_oe <= 1'b0;
      read_active        <= 1'b0;
    end else if (frame_fall) begin
      read_active        <= read_pending;
      serial_data_out_oe <= read_pending;
      out_shift          <= {1'b1, read_addr, read_data};
      serial_data_out    <= 1'b0;
    // RULE_14 release output
    end else if (frame_rise) begin
      serial_data_out_oe <= 1'b0;
      read_active        <= 1'b0;
    // RULE_07 shift on rise
    end else if (!frame_n_s && sclk_rise && read_active) begin
      serial_data_out <= out_shift[23];
      out_shift       <= {out_shift[22:0], 1'b0};
    end
  end

  // registers and output update
  always @(posedge sys_clk) begin
    if (dev_rst) begin
      input_reg      <= `DSL_DAC_RESET;
      dac_code       <= `DSL_DAC_RESET;
      ctrl_reg       <= `DSL_CTRL_RESET;
      clear_code     <= `DSL_CLR_RESET;
      twos_comp      <= 1'b0;
      update_pending <= 1'b0;
      read_pending   <= 1'b0;
      read_addr      <= 3'h0;
      output_update  <= 1'b0;
    end else begin
      output_update <= 1'b0;
      if (word_ok && !is_read) begin
        case (word_addr)
          `DSL_ADDR_DAC: begin
            input_reg <= word_data;
          end
          `DSL_ADDR_CTRL: begin
            ctrl_reg  <= word_data;
            twos_comp <= word_data[`DSL_CTRL_TWOS_BIT];
          end
          `DSL_ADDR_CLR: begin
            clear_code <= word_data;
          end
          default: begin
            ctrl_reg <= ctrl_reg;
          end
        endcase
      end
      if (word_ok && is_read) begin
        read_pending <= 1'b1;
        read_addr    <= word_addr;
      end else if (frame_rise && read_active) begin
        read_pending <= 1'b0;
      end
      // RULE_02 clear wins
      // level keeps forcing the code, only the fall reports an update
      if (!clear_n_s) begin
        dac_code       <= clear_code;
        update_pending <= 1'b0;
        output_update  <= clear_fall;
      // RULE_04 update at frame end
      end else if (word_ok && !is_read && word_addr == `DSL_ADDR_DAC
                   && !load_n_s) begin
        dac_code       <= word_data;
        update_pending <= 1'b0;
        output_update  <= 1'b1;
      // RULE_05 deferred load
      end else if (word_ok && !is_read && word_addr == `DSL_ADDR_DAC) begin
        update_pending <= 1'b1;
      end else if (load_fall && update_pending) begin
        dac_code       <= input_reg;
        update_pending <= 1'b0;
        output_update  <= 1'b1;
      end
    end
  end
endmodule // dsl_serial_load

// *** sim/dsl_serial_load_properties.sv ***
// port assertions for the serial load block
`timescale 1ns/100ps
module dsl_serial_load_properties (
  input wire        sys_clk,
  input wire        rst,
  input wire        reset_n,
  input wire        clear_n,
  input wire        load_output_n,
  input wire        frame_select_n,
  input wire        serial_clock,
  input wire        serial_data_in,
  input wire        serial_data_out_oe,
  input wire [19:0] dac_code,
  input wire [19:0] output_code,
  input wire        twos_comp,
  input wire        output_update
);
  reg        sc_d;
  reg [4:0]  n;
  reg [23:0] w;
  // counts sampled falls, as the block sees only synced pins
  always @(posedge sys_clk) begin
    sc_d <= serial_clock;
    if (rst || $fell(frame_select_n)) n <= 5'h00;
    else if (sc_d && !serial_clock && !frame_select_n) n <= n + 5'h01;
    // word copy so only converter writes are expected to update
    if (sc_d && !serial_clock && !frame_select_n)
      w <= {w[22:0], serial_data_in};
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_word_end;
    $rose(frame_select_n) && n == 5'h18 && clear_n;
  endsequence
  sequence s_bad_end;
    $rose(frame_select_n) && n != 5'h18 && clear_n;
  endsequence
  a_coding_map: assert property (
    output_code == (twos_comp ? {~dac_code[19], dac_code[18:0]} : dac_code))
    else $error("output code coding wrong");
  a_pulse_single: assert property (output_update |=> !output_update)
    else $error("update pulse too long");
  a_oe_release: assert property (
    frame_select_n[*6] |-> !serial_data_out_oe) else $error("output held");
  a_clear_hold: assert property (
    !clear_n[*6] |-> $stable(dac_code)) else $error("clear not held");
  a_idle_quiet: assert property (
    (frame_select_n && load_output_n && clear_n)[*8] |-> !output_update)
    else $error("update while idle");
  a_frame_acts: assert property (
    s_word_end ##0 (!load_output_n && w[23:20] == 4'h1)
    |-> ##[2:6] output_update)
    else $error("frame end did not update");
  a_clear_update: assert property (
    $fell(clear_n) && reset_n |-> ##[2:6] output_update)
    else $error("clear did not update");
  a_short_frame: assert property (
    s_bad_end |-> !output_update[*7]) else $error("short frame acted");
  a_reset_pin: assert property (
    $fell(reset_n) ##1 !reset_n[*5] |-> dac_code == 20'h00000
    && !twos_comp && !serial_data_out_oe) else $error("reset incomplete");
endmodule // dsl_serial_load_properties
bind dsl_serial_load dsl_serial_load_properties dsl_serial_load_props (
  .sys_clk            (sys_clk),
  .rst                (rst),
  .reset_n            (reset_n),
  .clear_n            (clear_n),
  .load_output_n      (load_output_n),
  .frame_select_n     (frame_select_n),
  .serial_clock       (serial_clock),
  .serial_data_in     (serial_data_in),
  .serial_data_out_oe (serial_data_out_oe),
  .dac_code           (dac_code),
  .output_code        (output_code),
  .twos_comp          (twos_comp),
  .output_update      (output_update)
);

// *** sim/dsl_host_model.sv ***
// serial master model that frames words into the block
`timescale 1ns/100ps
module dsl_host_model (
  input  wire sys_clk,
  input  wire serial_data_out,
  input  wire serial_data_out_oe,
  output reg  frame_select_n,
  output reg  serial_clock,
  output reg  serial_data_in
);
  initial begin
    frame_select_n = 1'b1;
    serial_clock = 1'b0;
    serial_data_in = 1'b0;
  end
  task xfer(input [23:0] w, input integer bits, output [23:0] rd);
    integer i;
    begin
      rd = 24'h000000;
      frame_select_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      for (i = bits - 1; i >= 0; i = i - 1) begin
        serial_clock <= 1'b1;
        serial_data_in <= w[i];
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk) rd = {rd[22:0], serial_data_out_oe ?
          serial_data_out : 1'bx};
        @(posedge sys_clk) serial_clock <= 1'b0;
        repeat (3) @(posedge sys_clk);
      end
      frame_select_n <= 1'b1;
      serial_data_in <= ~serial_data_in;
      repeat (8) @(posedge sys_clk);
    end
  endtask
endmodule // dsl_host_model

// *** sim/dsl_serial_load_tb.sv ***
// self-checking bench for the serial load block
`timescale 1ns/100ps
module dsl_serial_load_tb;
  reg         sys_clk = 1'b0, rst = 1'b1, reset_n = 1'b1, clear_n = 1'b1;
  reg         load_output_n = 1'b0, mon = 1'b1;
  wire        frame_select_n, serial_clock, serial_data_in, serial_data_out;
  wire        serial_data_out_oe, twos_comp, output_update;
  wire [19:0] dac_code, output_code;
  reg  [23:0] rd;
  reg  [19:0] v, c, e;
  reg  [31:0] r;
  reg  [19:0] q[$];
  integer     bad_count = 0, samples_checked = 0, seed = 62;
  always #4 sys_clk = ~sys_clk;
  dsl_serial_load dsl_serial_load_inst (
    .sys_clk            (sys_clk),
    .rst                (rst),
    .reset_n            (reset_n),
    .clear_n            (clear_n),
    .load_output_n      (load_output_n),
    .frame_select_n     (frame_select_n),
    .serial_clock       (serial_clock),
    .serial_data_in     (serial_data_in),
    .serial_data_out    (serial_data_out),
    .serial_data_out_oe (serial_data_out_oe),
    .dac_code           (dac_code),
    .output_code        (output_code),
    .twos_comp          (twos_comp),
    .output_update      (output_update)
  );
  dsl_host_model dsl_host_model_inst (
    .sys_clk            (sys_clk),
    .serial_data_out    (serial_data_out),
    .serial_data_out_oe (serial_data_out_oe),
    .frame_select_n     (frame_select_n),
    .serial_clock       (serial_clock),
    .serial_data_in     (serial_data_in)
  );
  task check(input [23:0] seen, input [23:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task settle(input [39:0] name);
    integer i;
    begin
      for (i = 0; i < 40 && q.size() != 0; i = i + 1) @(posedge sys_clk);
      repeat (12) @(posedge sys_clk);
      if (q.size() != 0) begin
        bad_count = bad_count + 1;
        finish_test;
      end else begin
        $display("%0s done", name);
      end
    end
  endtask
  // negedge sampling keeps clear of the register update race
  always @(negedge sys_clk) begin
    if (mon && output_update === 1'b1) begin
      e = q.size() != 0 ? q.pop_front() : ~dac_code;
      check({4'h0, dac_code}, {4'h0, e});
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    r = $random(seed);
    v = r[19:0];
    q.push_back(v);
    dsl_host_model_inst.xfer({4'h1, v}, 24, rd);
    settle("write");
    dsl_host_model_inst.xfer({4'h1, ~v}, 23, rd);
    settle("short");
    load_output_n <= 1'b1;
    dsl_host_model_inst.xfer({4'h9, 20'h00000}, 24, rd);
    dsl_host_model_inst.xfer(24'h000000, 24, rd);
    check(rd, {4'h9, v});
    check({23'h0, serial_data_out_oe}, 24'h000000);
    $display("read done");
    r = $random(seed);
    c = r[19:0];
    dsl_host_model_inst.xfer({4'h1, c}, 24, rd);
    settle("defer");
    q.push_back(c);
    load_output_n <= 1'b0;
    settle("load");
    load_output_n <= 1'b1;
    dsl_host_model_inst.xfer({4'h2, 20'h00002}, 24, rd);
    check({4'h0, output_code}, {4'h0, ~c[19], c[18:0]});
    r = $random(seed);
    v = r[19:0];
    dsl_host_model_inst.xfer({4'h3, v}, 24, rd);
    q.push_back(v);
    clear_n <= 1'b0;
    settle("clear");
    check({4'h0, output_code}, {4'h0, ~v[19], v[18:0]});
    clear_n <= 1'b1;
    mon = 1'b0;
    reset_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check({dac_code, 3'h0, twos_comp}, 24'h000000);
    $display("reset done");
    finish_test;
  end
endmodule // dsl_serial_load_tb
